//--- smp_capability_info_responder.sv
// What this block does
// - SATA expander answers function 02h request
// - Non-SATA device treats 02h as unknown
// - Byte 1 bit 0 reports SATA attach
// - Byte 1 bit 1 reports queued support
// - Byte 2 holds spec revision code
// - Byte 3 holds shared requester limit
// - Over-limit connection gets rejected
// - Byte 0 carries function result
// - Function 03h answered when enabled
// - Byte 4 holds length 33h
// - Length never trimmed for short requests
// - ASCII bytes only 20h to 7Eh
// - Strings left aligned, space padded
// - Vendor name bytes 8-15, MSB first
// - Product name bytes 16-31
// - Revision bytes 32-35, then vendor bytes
`timescale 1ns/100ps
`default_nettype none
module smp_capability_info_responder #(
    parameter bit SATA_EXPANDER = 1'b1,
    parameter bit MAKER_INFO_EN = 1'b1,
    parameter bit QUEUED_DEFAULT = 1'b0,
    // Arbitrary identification strings, ASCII, MSB is first byte
    parameter logic [63:0] VENDOR_ID = 64'h47454e4552494320,
    parameter logic [127:0] PRODUCT_ID =
        128'h534d5020524553504f4e444552202020,
    parameter logic [31:0] REVISION = 32'h30303031,
    parameter logic [159:0] VENDOR_SPEC = 160'h0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Request byte stream
    input wire smp_info_pkg::byte_beat_type req_i,
    output logic req_ready_o,
    // Response byte stream
    output smp_info_pkg::byte_beat_type rsp_o,
    input wire logic rsp_ready_i,
    // Connection requests toward a shared target
    input wire logic open_req_i,
    input wire logic [7:0] open_sharers_i,
    output logic open_accept_o,
    output logic open_reject_o
);
    // Software state
    logic cfg_queue_r; // Queued command support flag
    logic [7:0] rev_code_r; // Spec revision code
    logic [7:0] limit_r; // Shared requester limit
    logic [7:0] rej_cnt_r; // Rejected connection count
    logic [7:0] last_fn_r; // Last decoded function code
    logic [31:0] rdata_r;
    // Frame state
    smp_info_pkg::resp_state_type state_r;
    smp_info_pkg::resp_kind_type kind_r;
    logic [2:0] req_cnt_r; // Request bytes seen, saturates
    logic [7:0] fn_r; // Function code held from byte 0
    logic [5:0] idx_r; // Index of byte now presented
    smp_info_pkg::byte_beat_type rsp_r;
    logic req_ready_r;
    logic accept_r;
    logic reject_r;

    // Non-graphic codes become spaces, so null-padded strings pad right
    function automatic logic [7:0] ascii(input logic [7:0] b);
        return (b < smp_info_pkg::ASCII_SPACE || b > smp_info_pkg::ASCII_MAX)
            ? smp_info_pkg::ASCII_SPACE : b;
    endfunction

    // Response byte at a given index for the decoded function
    function automatic logic [7:0] resp_byte(
        input smp_info_pkg::resp_kind_type kind,
        input logic [5:0] idx
    );
        logic [7:0] b;
        b = 8'h00; // Reserved bytes read as zero
        if (idx == smp_info_pkg::OFS_RESULT) begin
            // Result first in all three response kinds
            b = (kind == smp_info_pkg::KIND_UNK)
                ? smp_info_pkg::RES_UNKNOWN_FN
                : smp_info_pkg::RES_ACCEPTED;
        end else if (kind == smp_info_pkg::KIND_CAP) begin
            if (idx == smp_info_pkg::OFS_ATTACH) begin
                b = {6'h00, cfg_queue_r, SATA_EXPANDER};
            end else if (idx == smp_info_pkg::OFS_REV) begin
                b = rev_code_r;
            end else if (idx == smp_info_pkg::OFS_LIMIT) begin
                b = limit_r;
            end
        end else if (kind == smp_info_pkg::KIND_INFO) begin
            if (idx == smp_info_pkg::OFS_LEN) begin
                // Fixed, whatever the request asked
                b = smp_info_pkg::PARAM_BYTE_COUNT;
            end else if (idx >= smp_info_pkg::OFS_VENDOR_LO &&
                         idx <= smp_info_pkg::OFS_VENDOR_HI) begin
                b = ascii(8'(VENDOR_ID >>
                    {smp_info_pkg::OFS_VENDOR_HI - idx, 3'h0}));
            end else if (idx > smp_info_pkg::OFS_VENDOR_HI &&
                         idx <= smp_info_pkg::OFS_PRODUCT_HI) begin
                b = ascii(8'(PRODUCT_ID >>
                    {smp_info_pkg::OFS_PRODUCT_HI - idx, 3'h0}));
            end else if (idx > smp_info_pkg::OFS_PRODUCT_HI &&
                         idx <= smp_info_pkg::OFS_REVSTR_HI) begin
                b = ascii(8'(REVISION >>
                    {smp_info_pkg::OFS_REVSTR_HI - idx, 3'h0}));
            end else if (idx > smp_info_pkg::OFS_REVSTR_HI) begin
                b = 8'(VENDOR_SPEC >>
                    {smp_info_pkg::OFS_VSPEC_HI - idx, 3'h0});
            end
        end
        return b;
    endfunction

    // Request decode
    wire req_take = req_i.valid && req_ready_r;
    wire req_end = req_take && req_i.last;
    wire [7:0] fn_now = (req_cnt_r == 3'h0) ? req_i.data : fn_r;
    // Function 02h only exists on a SATA expander
    wire cap_hit = SATA_EXPANDER &&
        fn_now == smp_info_pkg::FN_SERIAL_ATA_FEATURE_REPORT;
    wire info_hit = MAKER_INFO_EN &&
        fn_now == smp_info_pkg::FN_MAKER_INFO_REPORT;
    wire smp_info_pkg::resp_kind_type kind_nxt =
        cap_hit ? smp_info_pkg::KIND_CAP :
        info_hit ? smp_info_pkg::KIND_INFO : smp_info_pkg::KIND_UNK;
    // Unknown functions answer result plus three zero bytes
    wire [5:0] last_idx = (kind_r == smp_info_pkg::KIND_INFO)
        ? smp_info_pkg::INFO_LAST : smp_info_pkg::CAP_LAST;
    wire rsp_step = rsp_r.valid && rsp_ready_i;
    wire [5:0] idx_nxt = idx_r + 6'h01;

    // Register decode
    wire wr_cfg = reg_wr_i && reg_addr_i == smp_info_pkg::REG_CFG;
    wire wr_rev = reg_wr_i && reg_addr_i == smp_info_pkg::REG_REV;
    wire wr_limit = reg_wr_i && reg_addr_i == smp_info_pkg::REG_LIMIT;
    wire [31:0] status_word = {8'h00, rej_cnt_r, last_fn_r, 7'h00,
        state_r == smp_info_pkg::ST_TX};
    wire [31:0] rd_mux =
        reg_addr_i == smp_info_pkg::REG_CFG ?
            {30'h0, cfg_queue_r, SATA_EXPANDER} :
        reg_addr_i == smp_info_pkg::REG_REV ? {24'h0, rev_code_r} :
        reg_addr_i == smp_info_pkg::REG_LIMIT ? {24'h0, limit_r} :
        reg_addr_i == smp_info_pkg::REG_STATUS ? status_word : 32'h0;

    // Connection limit check
    wire over_limit = open_sharers_i >= limit_r;

    // Software registers; read data valid one cycle after strobe
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cfg_queue_r <= QUEUED_DEFAULT;
            rev_code_r <= smp_info_pkg::SPEC_REV_1_0;
            limit_r <= smp_info_pkg::LIMIT_RST;
            rdata_r <= 32'h0;
        end else begin
            if (wr_cfg) begin
                cfg_queue_r <= reg_wdata_i[smp_info_pkg::CFG_QUEUE_BIT];
            end
            if (wr_rev) rev_code_r <= reg_wdata_i[7:0];
            if (wr_limit) limit_r <= reg_wdata_i[7:0];
            rdata_r <= reg_rd_i ? rd_mux : 32'h0;
        end
    end

    // Connection accept or reject, one cycle after the request
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            accept_r <= 1'b0;
            reject_r <= 1'b0;
            rej_cnt_r <= smp_info_pkg::REJ_CNT_RST;
        end else begin
            accept_r <= open_req_i && !over_limit;
            reject_r <= open_req_i && over_limit;
            // Counter sticks at all ones rather than wrapping
            if (open_req_i && over_limit && rej_cnt_r != 8'hff) begin
                rej_cnt_r <= rej_cnt_r + 8'h01;
            end
        end
    end

    // Request collection; bytes past the header are ignored
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            req_cnt_r <= 3'h0;
            fn_r <= 8'h00;
            last_fn_r <= 8'h00;
        end else if (req_take) begin
            if (req_cnt_r == 3'h0) fn_r <= req_i.data;
            if (req_end) begin
                req_cnt_r <= 3'h0;
                last_fn_r <= fn_now;
            end else if (req_cnt_r != smp_info_pkg::REQ_HDR_BYTES) begin
                req_cnt_r <= req_cnt_r + 3'h1;
            end
        end
    end

    // Response sequencer, bytes go out from index 0 upward
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_r <= smp_info_pkg::ST_RX;
            kind_r <= smp_info_pkg::KIND_UNK;
            idx_r <= 6'h00;
            rsp_r <= '0;
            req_ready_r <= 1'b1;
        end else begin
            unique case (state_r)
                smp_info_pkg::ST_RX: begin
                    // Request done: present byte 0 at once
                    if (req_end) begin
                        state_r <= smp_info_pkg::ST_TX;
                        kind_r <= kind_nxt;
                        idx_r <= 6'h00;
                        req_ready_r <= 1'b0;
                        rsp_r.valid <= 1'b1;
                        rsp_r.last <= 1'b0;
                        rsp_r.data <= resp_byte(kind_nxt, 6'h00);
                    end
                end
                smp_info_pkg::ST_TX: begin
                    if (rsp_step && rsp_r.last) begin
                        // Final byte taken; accept the next request
                        state_r <= smp_info_pkg::ST_RX;
                        rsp_r <= '0;
                        req_ready_r <= 1'b1;
                    end else if (rsp_step) begin
                        idx_r <= idx_nxt;
                        rsp_r.last <= idx_nxt == last_idx;
                        rsp_r.data <= resp_byte(kind_r, idx_nxt);
                    end
                end
            endcase
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_o = rdata_r;
    assign req_ready_o = req_ready_r;
    assign rsp_o = rsp_r;
    assign open_accept_o = accept_r;
    assign open_reject_o = reject_r;

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    wire cap_beat = rsp_r.valid && kind_r == smp_info_pkg::KIND_CAP;
    wire info_beat = rsp_r.valid && kind_r == smp_info_pkg::KIND_INFO;

    a_cap_flag_byte: assert property (
        cap_beat && idx_r == smp_info_pkg::OFS_ATTACH |->
        rsp_r.data == {6'h00, cfg_queue_r, SATA_EXPANDER})
        else $error("capability flag byte wrong");
    a_cap_rev_byte: assert property (
        cap_beat && idx_r == smp_info_pkg::OFS_REV |->
        rsp_r.data == rev_code_r)
        else $error("revision code byte wrong");
    a_cap_limit_byte: assert property (
        cap_beat && idx_r == smp_info_pkg::OFS_LIMIT |-> rsp_r.data == limit_r)
        else $error("limit byte wrong");
    a_open_reject_limit: assert property (
        open_req_i && open_sharers_i >= limit_r |=>
        open_reject_o && !open_accept_o)
        else $error("over-limit connection not rejected");
    a_result_first_byte: assert property (
        $rose(rsp_r.valid) |-> idx_r == 6'h00 && rsp_r.data ==
        (kind_r == smp_info_pkg::KIND_UNK ? smp_info_pkg::RES_UNKNOWN_FN
            : smp_info_pkg::RES_ACCEPTED))
        else $error("result byte wrong");
    a_info_len_byte: assert property (
        info_beat && idx_r == smp_info_pkg::OFS_LEN |->
        rsp_r.data == smp_info_pkg::PARAM_BYTE_COUNT)
        else $error("length byte wrong");
    a_ascii_graphic_only: assert property (
        info_beat && idx_r >= smp_info_pkg::OFS_VENDOR_LO &&
        idx_r <= smp_info_pkg::OFS_REVSTR_HI |->
        rsp_r.data >= 8'h20 && rsp_r.data <= 8'h7e)
        else $error("non-graphic ASCII byte");
    a_no_sata_fn: assert property (
        !SATA_EXPANDER && state_r == smp_info_pkg::ST_TX |->
        kind_r != smp_info_pkg::KIND_CAP)
        else $error("capability report on non-SATA device");
    a_byte_ascending: assert property (
        rsp_step && !rsp_r.last |=>
        rsp_r.valid && idx_r == $past(idx_r) + 6'h01)
        else $error("response bytes out of order");
    a_frame_length: assert property (
        rsp_r.valid && rsp_r.last |-> idx_r == last_idx)
        else $error("response length wrong");

    c_cap_resp: cover property (cap_beat && rsp_r.last && rsp_ready_i);
    c_info_resp: cover property (info_beat && rsp_r.last && rsp_ready_i);
    c_open_reject: cover property (open_reject_o);
endmodule
`default_nettype wire

//--- smp_info_pkg.sv
package smp_info_pkg;
    // Function codes carried in request byte 0
    localparam logic [7:0] FN_SERIAL_ATA_FEATURE_REPORT = 8'h02;
    localparam logic [7:0] FN_MAKER_INFO_REPORT = 8'h03;
    // Function result codes, only accepted and unknown used here
    localparam logic [7:0] RES_ACCEPTED = 8'h00;
    localparam logic [7:0] RES_UNKNOWN_FN = 8'h01;
    // Response contents
    localparam logic [7:0] SPEC_REV_1_0 = 8'h00;
    localparam logic [7:0] PARAM_BYTE_COUNT = 8'h33;
    localparam logic [7:0] ASCII_SPACE = 8'h20;
    localparam logic [7:0] ASCII_MAX = 8'h7e;
    // Response byte positions and lengths
    localparam logic [5:0] OFS_RESULT = 6'h00;
    localparam logic [5:0] OFS_ATTACH = 6'h01;
    localparam logic [5:0] OFS_REV = 6'h02;
    localparam logic [5:0] OFS_LIMIT = 6'h03;
    localparam logic [5:0] OFS_LEN = 6'h04;
    localparam logic [5:0] OFS_VENDOR_LO = 6'h08;
    localparam logic [5:0] OFS_VENDOR_HI = 6'h0f;
    localparam logic [5:0] OFS_PRODUCT_HI = 6'h1f;
    localparam logic [5:0] OFS_REVSTR_HI = 6'h23;
    localparam logic [5:0] OFS_VSPEC_HI = 6'h37;
    localparam logic [5:0] CAP_LAST = 6'h03;
    localparam logic [5:0] INFO_LAST = 6'h37;
    // Request bytes that carry the function code and reserved bytes
    localparam logic [2:0] REQ_HDR_BYTES = 3'h4;
    // Register byte addresses
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_REV = 4'h4;
    localparam logic [3:0] REG_LIMIT = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    // Field positions
    localparam int CFG_ATTACH_BIT = 0;
    localparam int CFG_QUEUE_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_FN_LSB = 8;
    localparam int ST_REJ_LSB = 16;
    // Reset values
    localparam logic [7:0] LIMIT_RST = 8'h01;
    localparam logic [7:0] REJ_CNT_RST = 8'h00;

    // One byte of a request or response stream
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } byte_beat_type;

    typedef enum logic [1:0] {KIND_UNK, KIND_CAP, KIND_INFO} resp_kind_type;
    typedef enum logic {ST_RX, ST_TX} resp_state_type;
endpackage

//--- smp_initiator_model.sv
`timescale 1ns/100ps
`default_nettype none
module smp_initiator_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Control from the bench
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic [7:0] fn_i,
    input wire logic [5:0] req_len_i,
    // Request stream toward the responder
    output smp_info_pkg::byte_beat_type req_o,
    input wire logic req_ready_i,
    // Response stream from the responder
    input wire smp_info_pkg::byte_beat_type rsp_i,
    output logic rsp_ready_o,
    // Collected response
    output logic done_o,
    output logic [6:0] rx_cnt_o,
    output logic [7:0] rx_o [0:63]
);
    logic [5:0] sent_r; // Request bytes handed over so far

    // Sends a frame, then gathers the answer bytes in order
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            req_o <= '0;
            sent_r <= 6'h00;
            done_o <= 1'b0;
            rx_cnt_o <= 7'h00;
            rsp_ready_o <= 1'b1;
        end else begin
            // Slow mode stalls every other cycle
            rsp_ready_o <= slow_i ? ~rsp_ready_o : 1'b1;
            if (start_i) begin
                req_o.valid <= 1'b1;
                req_o.data <= fn_i;
                req_o.last <= (req_len_i == 6'h01);
                sent_r <= 6'h01;
                done_o <= 1'b0;
                rx_cnt_o <= 7'h00;
            end else if (req_o.valid && req_ready_i) begin
                if (req_o.last) begin
                    // Released line shows no stale byte
                    req_o.valid <= 1'b0;
                    req_o.last <= 1'b0;
                    req_o.data <= ~req_o.data;
                end else begin
                    req_o.data <= 8'h00;
                    req_o.last <= (sent_r + 6'h01 == req_len_i);
                    sent_r <= sent_r + 6'h01;
                end
            end
            // Bytes are stored by arrival, so order is checked too
            if (rsp_i.valid && rsp_ready_o) begin
                rx_o[rx_cnt_o[5:0]] <= rsp_i.data;
                rx_cnt_o <= rx_cnt_o + 7'h01;
                if (rsp_i.last) begin
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- smp_capability_info_responder_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module smp_capability_info_responder_bench;
    // Identification strings, arbitrary; product ends in non-graphic bytes
    localparam logic [63:0] VEND = 64'h47454e4552494320;
    localparam logic [127:0] PROD = 128'h41420000000000000000000000000000;
    localparam logic [31:0] REVS = 32'h30303031;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    smp_info_pkg::byte_beat_type req_i, rsp_o;
    logic req_ready_o, rsp_ready_i;
    logic open_req_i = 1'b0;
    logic [7:0] open_sharers_i = 8'h00;
    logic open_accept_o, open_reject_o;
    logic start_r = 1'b0;
    logic slow_r = 1'b0;
    logic [7:0] fn_r = 8'h00;
    logic [5:0] len_r = 6'h04;
    logic done;
    logic [6:0] rx_cnt;
    logic [7:0] rx [0:63];
    // Responder built without serial-ATA attach, run in lockstep
    smp_info_pkg::byte_beat_type plain_rsp;
    logic [7:0] plain_first_r = 8'h00; // Its byte 0 of the last frame
    int num_errors = 0;
    int check_count = 0;

    smp_capability_info_responder #(.VENDOR_ID(VEND), .PRODUCT_ID(PROD),
        .REVISION(REVS)) dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .req_i(req_i), .req_ready_o(req_ready_o), .rsp_o(rsp_o),
        .rsp_ready_i(rsp_ready_i), .open_req_i(open_req_i),
        .open_sharers_i(open_sharers_i), .open_accept_o(open_accept_o),
        .open_reject_o(open_reject_o));
    // Same request stream and sink; frame lengths match, so beats align
    smp_capability_info_responder #(.SATA_EXPANDER(1'b0)) dut_plain (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(),
        .req_i(req_i), .req_ready_o(), .rsp_o(plain_rsp),
        .rsp_ready_i(rsp_ready_i), .open_req_i(open_req_i),
        .open_sharers_i(open_sharers_i), .open_accept_o(),
        .open_reject_o());
    // Keep the first beat, taken when the sink takes byte 0
    always_ff @(posedge core_clk_i) begin
        if (plain_rsp.valid && rsp_ready_i && rx_cnt == 7'h00) begin
            plain_first_r <= plain_rsp.data;
        end
    end
    // Far-side requester
    smp_initiator_model initiator (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .start_i(start_r), .slow_i(slow_r), .fn_i(fn_r),
        .req_len_i(len_r), .req_o(req_i), .req_ready_i(req_ready_o),
        .rsp_i(rsp_o), .rsp_ready_o(rsp_ready_i), .done_o(done),
        .rx_cnt_o(rx_cnt), .rx_o(rx));

    // 50 MHz clock
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    // Register write, one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Register read, data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // One request frame and its whole answer, bounded wait
    task automatic xfer(input logic [7:0] fn, input logic [5:0] n,
                        input logic slow);
        int k;
        @(posedge core_clk_i);
        fn_r <= fn;
        len_r <= n;
        slow_r <= slow;
        start_r <= 1'b1;
        @(posedge core_clk_i);
        start_r <= 1'b0;
        k = 0;
        // Done from the previous frame is cleared on this edge; look after it
        #1;
        while (done !== 1'b1 && k < 500) begin
            @(posedge core_clk_i);
            #1;
            k++;
            // No new request taken while a response is out
            `CHK(rsp_o.valid & req_ready_o, 1'b0)
        end
        `CHK(done, 1'b1)
        `CHK(req_ready_o, 1'b1)
    endtask

    // Reset values and an unmapped place
    task automatic test_regs;
        logic [31:0] d;
        rd(smp_info_pkg::REG_CFG, d);
        `CHK(d[7:0], 8'h01)
        rd(smp_info_pkg::REG_REV, d);
        `CHK(d[7:0], smp_info_pkg::SPEC_REV_1_0)
        rd(4'h2, d);
        `CHK(d, 32'h0)
    endtask

    // Capability report with queued support and limit 3, stalling sink
    task automatic test_cap;
        wr(smp_info_pkg::REG_CFG, 32'h2);
        wr(smp_info_pkg::REG_LIMIT, 32'h3);
        xfer(smp_info_pkg::FN_SERIAL_ATA_FEATURE_REPORT, 6'h04, 1'b1);
        `CHK(rx_cnt, 7'h04)
        `CHK(rx[0], smp_info_pkg::RES_ACCEPTED)
        `CHK(rx[1], 8'h03)
        `CHK(rx[2], 8'h00)
        `CHK(rx[3], 8'h03)
        // Device without serial-ATA attach treats the code as unknown
        `CHK(plain_first_r, smp_info_pkg::RES_UNKNOWN_FN)
    endtask

    // Back-to-back connections at the limit boundary
    task automatic test_open;
        logic [31:0] d;
        @(posedge core_clk_i);
        open_req_i <= 1'b1;
        open_sharers_i <= 8'h02;
        @(posedge core_clk_i);
        open_sharers_i <= 8'h03;
        #1 `CHK({open_accept_o, open_reject_o}, 2'b10)
        @(posedge core_clk_i);
        open_req_i <= 1'b0;
        #1 `CHK({open_accept_o, open_reject_o}, 2'b01)
        rd(smp_info_pkg::REG_STATUS, d);
        `CHK(d[23:16], 8'h01)
    endtask

    // Maker report, full frame then a one-byte frame
    task automatic test_info(input logic [5:0] n);
        logic [7:0] e;
        xfer(smp_info_pkg::FN_MAKER_INFO_REPORT, n, 1'b0);
        `CHK(rx_cnt, 7'h38)
        for (int i = 0; i < 56; i++) begin
            if (i == 4) e = 8'h33;
            else if (i < 8) e = 8'h00;
            else if (i < 16) e = VEND[63 - 8 * (i - 8) -: 8];
            else if (i < 32) e = PROD[127 - 8 * (i - 16) -: 8];
            else if (i < 36) e = REVS[31 - 8 * (i - 32) -: 8];
            else e = 8'h00;
            // Non-graphic product bytes must come out as spaces
            if (i >= 16 && i < 32 && (e < 8'h20 || e > 8'h7e)) e = 8'h20;
            `CHK(rx[i], e)
        end
    endtask

    // Unknown function gets a short refusal
    task automatic test_unknown;
        xfer(8'h10, 6'h04, 1'b0);
        `CHK(rx_cnt, 7'h04)
        `CHK({rx[0], rx[1], rx[2], rx[3]}, 32'h01000000)
    endtask

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #400000;
        num_errors++;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        test_regs;
        test_cap;
        test_open;
        test_info(6'h04);
        test_info(6'h01);
        test_unknown;
        tally_and_finish;
    end
endmodule
`default_nettype wire
